/* bench/dft_drive_model.sv */
// Drive-side model: fault sensors, keypad key and run switch
`timescale 1ns/1ps
module dft_drive_model import dft_pkg::*; (
    input wire logic [7:0] fault_code_in,
    input wire logic run_in,
    input wire logic key_in,
    input wire logic pwr_in,
    input wire logic [15:0] data_in,
    output dft_sense_t sense_out
);
    // One sensor per fault code except start guard 13, with one over-current sensor plus phase for codes 01-04; all others quiet
    always_comb begin
        sense_out = '0;
        sense_out.over_current = fault_code_in inside {CODE_OC_CONST, CODE_OC_DECEL, CODE_OC_ACCEL, CODE_OC_OTHER};
        sense_out.phase = dft_phase_t'(fault_code_in[1:0] - 2'h1);
        sense_out.bus_ov = fault_code_in == CODE_BUS_OV;
        sense_out.mem_fault = (fault_code_in == CODE_MEMORY) && !pwr_in;
        sense_out.rs_at_powerdown = pwr_in;
        sense_out.bus_uv = fault_code_in == CODE_BUS_UV;
        sense_out.cpu_fault_a = fault_code_in == CODE_CPU_A;
        sense_out.cpu_fault_b = fault_code_in == CODE_CPU_B;
        sense_out.external_fault_input = fault_code_in == CODE_EXTERNAL;
        sense_out.ground_fault = fault_code_in == CODE_GROUND;
        sense_out.input_ov = fault_code_in == CODE_INPUT_OV;
        sense_out.module_hot = fault_code_in == CODE_MODULE_HOT;
        sense_out.thermistor_hot = fault_code_in == CODE_THERMISTOR;
        sense_out.gate_array_fault = fault_code_in == CODE_GATE_ARRAY;
        sense_out.comm_wdt_expired = fault_code_in == CODE_COMM_WDT;
        sense_out.run_cmd = run_in;
        sense_out.stop_reset_key = key_in;
        sense_out.reset_input_terminal = key_in;
        sense_out.op_data = data_in;
    end
endmodule // dft_drive_model

/* bench/testbench.sv */
// Self-checking bench for the drive fault trip logger
`timescale 1ns/1ps
module testbench import dft_pkg::*;;
    localparam int unsigned STOP_CYC = 50;
    localparam int unsigned BROWN_CYC = 20;
    localparam logic [7:0] RUN_CODES [13] = '{CODE_OC_CONST, CODE_OC_DECEL, CODE_OC_ACCEL, CODE_OC_OTHER,
        CODE_BUS_OV, CODE_MEMORY, CODE_CPU_A, CODE_CPU_B, CODE_EXTERNAL, CODE_MODULE_HOT, CODE_GATE_ARRAY,
        CODE_THERMISTOR, CODE_COMM_WDT};
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    dft_sense_t sense;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic motor_en;
    logic tripped;
    logic rst_term;
    logic [7:0] disp_code;
    logic [7:0] fault_code = 8'h00;
    logic run = 1'b0;
    logic key = 1'b0;
    logic pwr = 1'b0;
    logic [15:0] op_data = 16'h0000;
    int miscompares = 0;
    int num_checks = 0;
    dft_entry_t hist [3];
    logic [31:0] rd;

    always #20 clk_sys_in = ~clk_sys_in;

    dft_drive_model MODEL (.fault_code_in(fault_code), .run_in(run), .key_in(key), .pwr_in(pwr),
        .data_in(op_data), .sense_out(sense));

    dft_trip_logger #(.STOP_TEST_CYC(STOP_CYC), .BROWNOUT_CYC(BROWN_CYC)) DUT (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .sense_in(sense), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .motor_enable_out(motor_en),
        .tripped_out(tripped), .display_code_out(disp_code), .reset_terminal_out(rst_term));

    task automatic end_of_test();
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Expected history after one more logged trip
    function automatic void push(input logic [7:0] c, input logic [15:0] s);
        hist[2] = hist[1];
        hist[1] = hist[0];
        hist[0] = '{code: c, snap: s};
    endfunction

    task automatic check_hist();
        logic [31:0] v;
        for (int i = 0; i < 3; i++) begin
            reg_read(4'(REG_HIST0 + i), v);
            check_val(v, {8'h00, hist[i].code, hist[i].snap});
        end
    endtask

    task automatic check_trip(input logic [7:0] c);
        logic [31:0] v;
        #1;
        check_val(32'(tripped), 32'h1);
        check_val(32'(disp_code), 32'(c));
        check_val(32'(motor_en), 32'h0);
        reg_read(REG_STATUS, v);
        check_val(v & 32'h0000ff01, {16'h0, c, 8'h01});
        check_hist();
    endtask

    // Key press clears the latched trip
    task automatic clear();
        fault_code <= 8'h00;
        run <= 1'b0;
        pwr <= 1'b0;
        tick(2);
        key <= 1'b1;
        tick(5);
        #1 check_val(32'(rst_term), 32'h1);
        @(posedge clk_sys_in);
        key <= 1'b0;
        tick(6);
        #1 check_val({23'h0, tripped, disp_code}, 32'h0);
    endtask

    task automatic trip_case(input logic [7:0] c, input int n, input logic r);
        @(posedge clk_sys_in);
        op_data <= 16'($urandom);
        run <= r;
        tick(6);
        #1 check_val(32'(motor_en), 32'(r));
        fault_code <= c;
        tick(n);
        push(c, op_data);
        check_trip(c);
        clear();
    endtask

    task automatic pwrup_case(input logic [7:0] c, input logic p);
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        fault_code <= c;
        pwr <= p;
        run <= (c == CODE_START_GUARD);
        tick(3);
        rst_n_in <= 1'b1;
        tick(6);
        hist = '{ENTRY_EMPTY, ENTRY_EMPTY, ENTRY_EMPTY};
        push(c, op_data);
        check_trip(c);
        clear();
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        miscompares++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'hb1ef));
        hist = '{ENTRY_EMPTY, ENTRY_EMPTY, ENTRY_EMPTY};
        tick(5);
        rst_n_in <= 1'b1;
        reg_read(REG_CTRL, rd);
        check_val(rd, 32'h0000_0003);
        reg_read(4'hf, rd);
        check_val(rd, 32'h0);
        reg_write(REG_HIST0, 32'hffff_ffff);
        check_hist();
        // thirteen fault codes from RUN_CODES, run or stop chosen at random
        foreach (RUN_CODES[i]) trip_case(RUN_CODES[i], 5, 1'($urandom));
        trip_case(CODE_INPUT_OV, STOP_CYC + 20, 1'b0);
        trip_case(CODE_BUS_UV, BROWN_CYC + 8, 1'b1);
        run <= 1'b1;
        tick(6);
        fault_code <= CODE_BUS_UV;
        tick(6);
        #1 check_val({motor_en, tripped}, 32'h0);
        reg_read(REG_STATUS, rd);
        check_val(rd & 32'h0000_0007, 32'h0000_0004);
        fault_code <= 8'h00;
        tick(10);
        #1 check_val({motor_en, tripped}, 32'h2);
        reg_read(REG_STATUS, rd);
        check_val(rd & 32'h0000_0007, 32'h0000_0002);
        // second fault while tripped not logged
        op_data <= 16'($urandom);
        fault_code <= CODE_MODULE_HOT;
        tick(5);
        push(CODE_MODULE_HOT, op_data);
        fault_code <= CODE_THERMISTOR;
        tick(5);
        check_trip(CODE_MODULE_HOT);
        clear();
        reg_write(REG_CTRL, 32'h0000_000b);
        check_hist();
        reg_read(REG_CTRL, rd);
        check_val(rd, 32'h0000_0003);
        reg_write(REG_CTRL, 32'h0000_0009);
        hist = '{ENTRY_EMPTY, ENTRY_EMPTY, ENTRY_EMPTY};
        check_hist();
        reg_read(REG_CTRL, rd);
        check_val(rd, 32'h0000_0001);
        trip_case(CODE_EXTERNAL, 5, 1'b1);
        reg_write(REG_CTRL, 32'h0000_0003);
        pwrup_case(CODE_START_GUARD, 1'b0);
        pwrup_case(CODE_GROUND, 1'b0);
        pwrup_case(CODE_MEMORY, 1'b1);
        end_of_test();
    end
endmodule // testbench

/* hw/dft_pkg.sv */
// Constants, codes and carrier types for the drive fault trip logger
package dft_pkg;
    // Clock and timing
    localparam longint unsigned CLK_HZ = 64'd25_000_000;
    localparam longint unsigned STOP_TEST_S = 64'd100;
    localparam longint unsigned BROWNOUT_MS = 64'd100;
    localparam int unsigned STOP_TEST_CYCLES = 32'(STOP_TEST_S * CLK_HZ);
    localparam int unsigned BROWNOUT_CYCLES = 32'(BROWNOUT_MS * CLK_HZ / 64'd1000);
    localparam logic [1:0] PWRUP_SETTLE = 2'h3;

    // Register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_HIST0 = 4'h2;
    localparam logic [3:0] REG_HIST1 = 4'h3;
    localparam logic [3:0] REG_HIST2 = 4'h4;

    // Control field positions and reset values
    localparam int CTRL_USP_BIT = 0;
    localparam int CTRL_SEL_LSB = 1;
    localparam int CTRL_EXEC_BIT = 3;
    localparam logic CTRL_USP_RST = 1'b1;
    localparam logic [1:0] INIT_SEL_RST = 2'h1;
    localparam logic [1:0] INIT_CLEAR_HISTORY = 2'h0;

    // Status field positions
    localparam int STAT_TRIP_BIT = 0;
    localparam int STAT_RUN_BIT = 1;
    localparam int STAT_BROWN_BIT = 2;
    localparam int STAT_CODE_LSB = 8;
    localparam int HIST_CODE_LSB = 16;

    // Error codes, shown as two hex digits
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_OC_CONST = 8'h01;
    localparam logic [7:0] CODE_OC_DECEL = 8'h02;
    localparam logic [7:0] CODE_OC_ACCEL = 8'h03;
    localparam logic [7:0] CODE_OC_OTHER = 8'h04;
    localparam logic [7:0] CODE_BUS_OV = 8'h07;
    localparam logic [7:0] CODE_MEMORY = 8'h08;
    localparam logic [7:0] CODE_BUS_UV = 8'h09;
    localparam logic [7:0] CODE_CPU_A = 8'h11;
    localparam logic [7:0] CODE_EXTERNAL = 8'h12;
    localparam logic [7:0] CODE_START_GUARD = 8'h13;
    localparam logic [7:0] CODE_GROUND = 8'h14;
    localparam logic [7:0] CODE_INPUT_OV = 8'h15;
    localparam logic [7:0] CODE_MODULE_HOT = 8'h21;
    localparam logic [7:0] CODE_CPU_B = 8'h22;
    localparam logic [7:0] CODE_GATE_ARRAY = 8'h23;
    localparam logic [7:0] CODE_THERMISTOR = 8'h35;
    localparam logic [7:0] CODE_COMM_WDT = 8'h60;

    typedef enum logic [1:0] {
        PH_CONST = 2'h0,
        PH_DECEL = 2'h1,
        PH_ACCEL = 2'h2,
        PH_OTHER = 2'h3
    } dft_phase_t;

    // Sensor and keypad levels from the drive pins
    typedef struct packed {
        logic over_current;
        dft_phase_t phase;
        logic bus_ov;
        logic mem_fault;
        logic bus_uv;
        logic cpu_fault_a;
        logic cpu_fault_b;
        logic external_fault_input;
        logic run_cmd;
        logic ground_fault;
        logic input_ov;
        logic module_hot;
        logic thermistor_hot;
        logic gate_array_fault;
        logic comm_wdt_expired;
        logic reset_input_terminal;
        logic rs_at_powerdown;
        logic stop_reset_key;
        logic [15:0] op_data;
    } dft_sense_t;

    typedef struct packed {
        logic [7:0] code;
        logic [15:0] snap;
    } dft_entry_t;

    localparam dft_entry_t ENTRY_EMPTY = '{code: 8'h00, snap: 16'h0000};
endpackage

/* hw/dft_trip_logger.sv */
// Fault trip latch, error code display and three-deep trip history
// Contract
// - Any fault latches trip, logs, output off
// - Trips also happen in stop mode
// - Stop/reset key clears active trip
// - Selector 00 execute clears history only
// - Trip shows its error code automatically
// - Over-current code follows motion phase
// - Bus over-voltage trips with its code
// - Memory fault trips, output off
// - Bus under-voltage trips, output off
// - Processor fault trips with either code
// - External fault input trips, output off
// - Input over-voltage tested after long stop
// - Module over-temperature trips, output off
// - Gate array link failure trips
// - Thermistor over-temperature trips, output off
// - Network watchdog expiry trips
// - Reset terminal at power-down gives memory error
// - Each trip stores operating data snapshot
// - History shifts newest to middle to oldest
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module dft_trip_logger import dft_pkg::*; #(
    parameter int unsigned STOP_TEST_CYC = STOP_TEST_CYCLES,
    parameter int unsigned BROWNOUT_CYC = BROWNOUT_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire dft_sense_t sense_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic motor_enable_out,
    output logic tripped_out,
    output logic [7:0] display_code_out,
    output logic reset_terminal_out
);
    dft_sense_t sync1_q, sync2_q;
    logic key_prev_q;
    logic tripped_q;
    logic [7:0] active_code_q;
    logic usp_en_q;
    logic [1:0] init_sel_q;
    logic [1:0] pwrup_cnt_q;
    logic pwrup_check_q;
    logic brownout_q;
    logic [31:0] brown_cnt_q;
    logic [31:0] stop_cnt_q;
    logic run_q;
    dft_entry_t hist_q [3];
    logic key_edge;
    logic fault_any;
    logic [7:0] fault_code;
    logic trip_new;
    logic hist_clear;
    logic stop_test_ready;
    logic brown_fail;

    // Two flip-flops on every pin level
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sense_in;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            key_prev_q <= 1'b0;
        end else begin
            key_prev_q <= sync2_q.stop_reset_key;
        end
    end

    assign key_edge = sync2_q.stop_reset_key && !key_prev_q;

    // One check pulse once the synchronisers have settled after power-up
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            pwrup_cnt_q <= '0;
            pwrup_check_q <= 1'b0;
        end else begin
            pwrup_check_q <= (pwrup_cnt_q == PWRUP_SETTLE - 2'h1);
            if (pwrup_cnt_q != PWRUP_SETTLE) begin
                pwrup_cnt_q <= pwrup_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            stop_cnt_q <= '0;
        end else if (run_q) begin
            stop_cnt_q <= '0;
        end else if (stop_cnt_q != STOP_TEST_CYC) begin
            stop_cnt_q <= stop_cnt_q + 32'h1;
        end
    end

    assign stop_test_ready = !run_q && (stop_cnt_q == STOP_TEST_CYC);

    // brown-out shutoff, restart on recovery, fail after window
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            brownout_q <= 1'b0;
            brown_cnt_q <= '0;
        end else if (!sync2_q.bus_uv || brown_fail) begin
            brownout_q <= 1'b0;
            brown_cnt_q <= '0;
        end else begin
            brownout_q <= 1'b1;
            brown_cnt_q <= brown_cnt_q + 32'h1;
        end
    end

    assign brown_fail = brownout_q && (brown_cnt_q >= BROWNOUT_CYC);

    // Fault priority encoder
    always_comb begin
        fault_any = 1'b1;
        fault_code = CODE_NONE;
        if (pwrup_check_q && sync2_q.rs_at_powerdown) begin
            fault_code = CODE_MEMORY;
        end else if (pwrup_check_q && sync2_q.ground_fault) begin
            fault_code = CODE_GROUND;
        end else if (pwrup_check_q && usp_en_q && sync2_q.run_cmd) begin
            fault_code = CODE_START_GUARD;
        end else if (sync2_q.over_current) begin
            unique case (sync2_q.phase)
                PH_CONST: fault_code = CODE_OC_CONST;
                PH_DECEL: fault_code = CODE_OC_DECEL;
                PH_ACCEL: fault_code = CODE_OC_ACCEL;
                PH_OTHER: fault_code = CODE_OC_OTHER;
            endcase
        end else if (sync2_q.bus_ov) begin
            fault_code = CODE_BUS_OV;
        end else if (sync2_q.mem_fault) begin
            fault_code = CODE_MEMORY;
        // failed restart is the under-voltage trip
        end else if (brown_fail) begin
            fault_code = CODE_BUS_UV;
        end else if (sync2_q.cpu_fault_a) begin
            fault_code = CODE_CPU_A;
        end else if (sync2_q.cpu_fault_b) begin
            fault_code = CODE_CPU_B;
        end else if (sync2_q.external_fault_input) begin
            fault_code = CODE_EXTERNAL;
        end else if (stop_test_ready && sync2_q.input_ov) begin
            fault_code = CODE_INPUT_OV;
        end else if (sync2_q.module_hot) begin
            fault_code = CODE_MODULE_HOT;
        end else if (sync2_q.gate_array_fault) begin
            fault_code = CODE_GATE_ARRAY;
        end else if (sync2_q.thermistor_hot) begin
            fault_code = CODE_THERMISTOR;
        end else if (sync2_q.comm_wdt_expired) begin
            fault_code = CODE_COMM_WDT;
        end else begin
            fault_any = 1'b0;
        end
    end

    // detection does not depend on run state, except input over-voltage, tested only when stopped, and start guard, which needs the run command at the power-up check
    assign trip_new = fault_any && (!tripped_q || key_edge);

    // latched trip, new fault wins over key clear
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tripped_q <= 1'b0;
            active_code_q <= CODE_NONE;
        end else if (trip_new) begin
            tripped_q <= 1'b1;
            active_code_q <= fault_code;
        end else if (key_edge) begin
            tripped_q <= 1'b0;
            active_code_q <= CODE_NONE;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            run_q <= 1'b0;
        end else begin
            // Held off until the power-up checks have had their say
            run_q <= sync2_q.run_cmd && !brownout_q && !sync2_q.bus_uv && !trip_new
                && !(tripped_q && !key_edge) && (pwrup_cnt_q == PWRUP_SETTLE);
        end
    end

    assign motor_enable_out = run_q;
    assign tripped_out = tripped_q;

    // error code on display while tripped
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            display_code_out <= CODE_NONE;
        end else if (trip_new) begin
            display_code_out <= fault_code;
        end else if (key_edge) begin
            display_code_out <= CODE_NONE;
        end
    end

    // reset terminal level for nonvolatile capture
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            reset_terminal_out <= 1'b0;
        end else begin
            reset_terminal_out <= sync2_q.reset_input_terminal;
        end
    end

    // selector 00 with execute clears history only
    assign hist_clear = reg_wr_in && (reg_addr_in == REG_CTRL) && reg_wdata_in[CTRL_EXEC_BIT]
        && (reg_wdata_in[CTRL_SEL_LSB +: 2] == INIT_CLEAR_HISTORY);

    for (genvar i = 0; i < 3; i++) begin : g_hist
        if (i == 0) begin : g_newest
            always_ff @(posedge clk_sys_in) begin
                if (!rst_n_in) begin
                    hist_q[i] <= ENTRY_EMPTY;
                end else if (trip_new) begin
                    hist_q[i] <= '{code: fault_code, snap: sync2_q.op_data};
                end else if (hist_clear) begin
                    hist_q[i] <= ENTRY_EMPTY;
                end
            end
        end else begin : g_older
            always_ff @(posedge clk_sys_in) begin
                if (!rst_n_in) begin
                    hist_q[i] <= ENTRY_EMPTY;
                end else if (hist_clear) begin
                    hist_q[i] <= ENTRY_EMPTY;
                end else if (trip_new) begin
                    hist_q[i] <= hist_q[i - 1];
                end
            end
        end
    end

    // Control register
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            usp_en_q <= CTRL_USP_RST;
            init_sel_q <= INIT_SEL_RST;
        end else if (reg_wr_in && (reg_addr_in == REG_CTRL)) begin
            usp_en_q <= reg_wdata_in[CTRL_USP_BIT];
            init_sel_q <= reg_wdata_in[CTRL_SEL_LSB +: 2];
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                REG_CTRL: reg_rdata_out <= {28'h0, 1'b0, init_sel_q, usp_en_q};
                REG_STATUS: reg_rdata_out <= {16'h0, active_code_q, 5'h0, brownout_q, run_q, tripped_q};
                REG_HIST0: reg_rdata_out <= {8'h0, hist_q[0]};
                REG_HIST1: reg_rdata_out <= {8'h0, hist_q[1]};
                REG_HIST2: reg_rdata_out <= {8'h0, hist_q[2]};
                default: reg_rdata_out <= '0;
            endcase
        end else begin
            reg_rdata_out <= '0;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    trip_latch_a: assert property (trip_new |=> tripped_q && active_code_q == $past(fault_code))
        else $error("Trip not latched with its code");
    trip_holds_a: assert property (tripped_q && !key_edge |=> tripped_q)
        else $error("Trip dropped without key");
    output_off_a: assert property (tripped_q && !key_edge |=> !run_q)
        else $error("Motor enabled while tripped");
    key_clear_a: assert property (tripped_q && key_edge && !fault_any |=> !tripped_q && display_code_out == CODE_NONE)
        else $error("Key did not clear trip");
    display_code_a: assert property (trip_new |=> display_code_out == $past(fault_code))
        else $error("Display code differs from trip code");
    stop_trip_a: assert property (!run_q && !tripped_q && sync2_q.module_hot |=> tripped_q)
        else $error("No trip in stop mode");
    hist_shift_a: assert property (trip_new && !hist_clear |=> hist_q[1] == $past(hist_q[0])
        && hist_q[2] == $past(hist_q[1]) && hist_q[0].code == $past(fault_code))
        else $error("History did not shift");
    hist_clear_a: assert property (hist_clear && !trip_new |=> hist_q[0] == ENTRY_EMPTY
        && hist_q[1] == ENTRY_EMPTY && hist_q[2] == ENTRY_EMPTY)
        else $error("History not cleared");
    snap_store_a: assert property (trip_new |=> hist_q[0].snap == $past(sync2_q.op_data))
        else $error("Snapshot not stored");
    input_ov_gate_a: assert property (fault_code == CODE_INPUT_OV |-> stop_cnt_q == STOP_TEST_CYC && !run_q)
        else $error("Input over-voltage tested too early");
    oc_phase_a: assert property (sync2_q.over_current && sync2_q.phase == PH_ACCEL && !pwrup_check_q
        && !tripped_q |=> active_code_q == CODE_OC_ACCEL)
        else $error("Over-current phase code wrong");
    trip_off_a: assert property (trip_new |=> !run_q)
        else $error("Motor left on at trip");
    bus_ov_a: assert property (sync2_q.bus_ov && !sync2_q.over_current && !pwrup_check_q && !tripped_q
        |=> tripped_q && active_code_q == CODE_BUS_OV)
        else $error("Bus over-voltage code wrong");
    mem_trip_a: assert property (sync2_q.mem_fault && !tripped_q |=> tripped_q && !run_q)
        else $error("Memory fault did not trip");
    mem_code_a: assert property (sync2_q.mem_fault && !sync2_q.over_current && !sync2_q.bus_ov
        && !pwrup_check_q && !tripped_q |=> active_code_q == CODE_MEMORY)
        else $error("Memory fault code wrong");
    uv_trip_a: assert property (brown_fail && !tripped_q |=> tripped_q && !run_q)
        else $error("Failed restart did not trip");
    uv_code_a: assert property (brown_fail && !sync2_q.over_current && !sync2_q.bus_ov && !sync2_q.mem_fault
        && !pwrup_check_q && !tripped_q |=> active_code_q == CODE_BUS_UV)
        else $error("Under-voltage code wrong");
    cpu_trip_a: assert property ((sync2_q.cpu_fault_a || sync2_q.cpu_fault_b) && !tripped_q |=> tripped_q && !run_q)
        else $error("Processor fault did not trip");
    ext_trip_a: assert property (sync2_q.external_fault_input && !tripped_q |=> tripped_q && !run_q)
        else $error("External fault did not trip");
    guard_trip_a: assert property (pwrup_check_q && usp_en_q && sync2_q.run_cmd |=> tripped_q && !run_q)
        else $error("Guarded start did not trip");
    pwrup_run_a: assert property (pwrup_cnt_q != PWRUP_SETTLE |=> !run_q)
        else $error("Motor ran before power-up checks");
    ground_code_a: assert property (pwrup_check_q && sync2_q.ground_fault && !sync2_q.rs_at_powerdown
        && !tripped_q |=> active_code_q == CODE_GROUND)
        else $error("Ground fault code wrong");
    nv_code_a: assert property (pwrup_check_q && sync2_q.rs_at_powerdown && !tripped_q
        |=> active_code_q == CODE_MEMORY)
        else $error("Reset terminal flag not reported");
    input_ov_trip_a: assert property (stop_test_ready && sync2_q.input_ov && !tripped_q |=> tripped_q)
        else $error("Input over-voltage did not trip");
    stop_reset_a: assert property (run_q |=> stop_cnt_q == 32'h0)
        else $error("Stop timer not restarted by run");
    hot_trip_a: assert property (sync2_q.module_hot && !tripped_q |=> tripped_q && !run_q)
        else $error("Module over-temperature did not trip");
    gate_trip_a: assert property (sync2_q.gate_array_fault && !tripped_q |=> tripped_q)
        else $error("Gate array failure did not trip");
    therm_trip_a: assert property (sync2_q.thermistor_hot && !tripped_q |=> tripped_q && !run_q)
        else $error("Thermistor did not trip");
    wdt_trip_a: assert property (sync2_q.comm_wdt_expired && !tripped_q |=> tripped_q)
        else $error("Watchdog expiry did not trip");
    uv_off_a: assert property (sync2_q.bus_uv |=> !run_q)
        else $error("Motor on during brown-out");
    uv_restart_a: assert property ($rose(sync2_q.bus_uv) && !fault_any && !tripped_q |=> !tripped_q)
        else $error("Brown-out tripped at once");
    hist_hold_a: assert property (!trip_new && !hist_clear
        |=> $stable(hist_q[0]) && $stable(hist_q[1]) && $stable(hist_q[2]))
        else $error("History changed without event");
    hist_fill_a: assert property (hist_clear && trip_new |=> hist_q[0].code == $past(fault_code)
        && hist_q[1] == ENTRY_EMPTY && hist_q[2] == ENTRY_EMPTY)
        else $error("Cleared history not filled newest first");
endmodule // dft_trip_logger
